// [shared/vbcs_pkg.sv]
// shared constants and carrier types for the video board bus cycle sequencer
package vbcs_pkg;
  // clock and vector timing
  localparam int CLK_PERIOD_PS = 4000; // 250 MHz core clock
  localparam int VEC_PERIOD_NS = 200; // one vector per 5 MHz period
  localparam int CAP_DELAY_NS = 100; // capture at mid-period
  localparam int VEC_CYC = (VEC_PERIOD_NS * 1000) / CLK_PERIOD_PS; // longest time rounds down
  localparam int CAP_CYC = (CAP_DELAY_NS * 1000) / CLK_PERIOD_PS;
  localparam int CNT_W = 6; // holds VEC_CYC - 1
  localparam logic [CNT_W-1:0] VEC_LAST = CNT_W'(VEC_CYC - 1);
  localparam logic [CNT_W-1:0] CAP_POINT = CNT_W'(CAP_CYC);
  localparam int OFS_W = 4; // capture offset width
  // address regions, top nibble of the 20-bit byte address
  localparam logic [3:0] CTRL_REGION = 4'hf;
  localparam logic [3:0] VRAM_REGION = 4'he;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [10:0] ADDR_RESET = 11'h000;

  // sequencer states, gray along idle-setup-strobe-hold-final
  typedef enum logic [2:0] {
    VBCS_IDLE = 3'h0,
    VBCS_SETUP = 3'h1,
    VBCS_STROBE = 3'h3,
    VBCS_HOLD = 3'h2,
    VBCS_FINAL = 3'h6
  } vbcs_state_t;

  // one bus cycle request
  typedef struct packed {
    logic write; // 1 write, 0 read
    logic extra_hold; // read: capture with strobes still low
    logic [19:0] addr; // byte address, bit 0 is a0
    logic [15:0] data; // write data
  } vbcs_cmd_t;

  // pins driven toward the video board, strobes active low
  typedef struct packed {
    logic [10:0] addr; // word address a11..a1
    logic a0; // spare pin carrying a0
    logic [15:0] data;
    logic data_oe; // high while data is driven
    logic rw; // 1 read, 0 write
    logic high_byte_strobe_n;
    logic low_byte_strobe_n;
    logic address_strobe_n;
    logic ctrl_page_select_n;
    logic vram_page_select_n;
  } vbcs_bus_t;
endpackage

// [src/vbcs_vec_timer.sv]
// vector period timer: counts clock cycles within one vector
`timescale 1ns/10ps
`default_nettype none
module vbcs_vec_timer
  import vbcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic restart_i,
  output logic [CNT_W-1:0] count_o,
  output logic tick_o
);
  // whole state of the timer
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } vbcs_tmr_t;

  vbcs_tmr_t r;
  vbcs_tmr_t next_r;

  // restart on a new vector, wrap at period end
  always_comb begin
    next_r = r;
    if (restart_i || r.cnt == VEC_LAST) begin
      next_r.cnt = '0;
    end else begin
      next_r.cnt = r.cnt + CNT_W'(1);
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign count_o = r.cnt;
  assign tick_o = (r.cnt == VEC_LAST); // last cycle of the vector
endmodule
`default_nettype wire

// [src/vbcs_sequencer.sv]
// bus cycle sequencer driving write and read cycles into the video board
// Operation
// - wait input is AND of both acks
// - page selects by region, gated by address strobe
// - controller low byte, video ram full word; controller byte strobe follows a0 instead
// - one vector per 200 ns period
// - drive word address lines a11 to a1
// - write: address, then data and strobes low
// - halt until ack falls, then final vector
// - read: same shape, direction kept high
// - capture data mid final read vector
// - programmable capture offset shifts sampling later
// - optional extra vector holding read strobes low
// - a0 picks low or high byte strobe
// - video ram swaps select, both strobes
`timescale 1ns/10ps
`default_nettype none
module vbcs_sequencer
  import vbcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic start_i, // request, taken when ready_o
  input wire vbcs_cmd_t cmd_i,
  input wire logic [OFS_W-1:0] capture_offset_i, // extra cycles after mid-period
  input wire logic controller_ack_n_i,
  input wire logic vram_ack_n_i,
  output logic ready_o,
  output logic done_o,
  output logic transfer_ack_n_o,
  output vbcs_bus_t bus_o,
  input wire logic [15:0] bus_data_i,
  output logic [15:0] rd_data_o,
  output logic rd_valid_o
);
  // whole state of the sequencer
  typedef struct packed {
    vbcs_state_t st;
    vbcs_cmd_t cmd;
    logic ack_q; // previous combined ack level
    logic ack_seen; // falling edge seen in strobe vector
    logic period_done; // strobe vector has lasted one period
    logic done;
    logic rd_valid;
    logic [15:0] rd_data;
    vbcs_bus_t bus;
  } vbcs_seq_t;

  vbcs_seq_t r;
  vbcs_seq_t next_r;
  logic transfer_ack_n; // combined acknowledge
  logic ack_fall;
  logic tick;
  logic [CNT_W-1:0] count;
  logic restart;
  logic [CNT_W-1:0] cap_at;
  logic [7:0] chk_len; // check helper: cycles spent in the current state
  localparam logic [7:0] LEN_VEC = 8'(VEC_CYC); // one vector in clock cycles, for checks

  // pin pattern for a given vector
  function automatic vbcs_bus_t drive(input vbcs_state_t st, input vbcs_cmd_t c);
    vbcs_bus_t b;
    logic vram;
    logic active;
    vram = (c.addr[19:16] == VRAM_REGION);
    active = (st == VBCS_STROBE) || (st == VBCS_HOLD);
    b.addr = c.addr[11:1];
    b.a0 = c.addr[0];
    b.data = c.data;
    // write data stays on through the final vector
    b.data_oe = c.write && (st != VBCS_IDLE) && (st != VBCS_SETUP);
    b.rw = !(active && c.write);
    b.address_strobe_n = !active;
    // page select only while the address strobe is low
    b.ctrl_page_select_n = !(active && c.addr[19:16] == CTRL_REGION);
    b.vram_page_select_n = !(active && vram);
    // odd address takes the low byte, video ram takes both
    b.low_byte_strobe_n = !(active && (vram || c.addr[0]));
    b.high_byte_strobe_n = !(active && (vram || !c.addr[0]));
    return b;
  endfunction

  assign transfer_ack_n = controller_ack_n_i & vram_ack_n_i;
  assign ack_fall = r.ack_q && !transfer_ack_n;
  assign cap_at = CAP_POINT + CNT_W'(capture_offset_i);
  assign restart = (next_r.st != r.st); // each vector starts a fresh period

  // vector period timer
  vbcs_vec_timer u_timer (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .restart_i(restart),
    .count_o(count),
    .tick_o(tick)
  );

  // next-state logic
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.rd_valid = 1'b0;
    next_r.ack_q = transfer_ack_n;
    case (r.st)
      // wait for a request
      VBCS_IDLE: begin
        if (start_i) begin
          next_r.cmd = cmd_i;
          next_r.st = VBCS_SETUP;
        end
      end
      // address only, controls high
      VBCS_SETUP: begin
        if (tick) begin
          next_r.st = VBCS_STROBE;
          next_r.ack_seen = 1'b0;
          next_r.period_done = 1'b0;
        end
      end
      // strobes low, halt until the ack falls
      VBCS_STROBE: begin
        if (ack_fall) begin
          next_r.ack_seen = 1'b1;
        end
        if (tick) begin
          next_r.period_done = 1'b1;
        end
        if ((r.ack_seen || ack_fall) && (r.period_done || tick)) begin
          if (!r.cmd.write && r.cmd.extra_hold) begin
            next_r.st = VBCS_HOLD;
          end else begin
            next_r.st = VBCS_FINAL;
          end
        end
      end
      // read strobes kept low while capturing
      VBCS_HOLD: begin
        if (count == cap_at) begin
          next_r.rd_data = bus_data_i;
          next_r.rd_valid = 1'b1;
        end
        if (tick) begin
          next_r.st = VBCS_FINAL;
        end
      end
      // controls back high, address held
      VBCS_FINAL: begin
        if (count == cap_at && !r.cmd.write && !r.cmd.extra_hold) begin
          next_r.rd_data = bus_data_i;
          next_r.rd_valid = 1'b1;
        end
        if (tick) begin
          next_r.st = VBCS_IDLE;
          next_r.done = 1'b1;
        end
      end
      default: begin
        next_r.st = VBCS_IDLE;
      end
    endcase
    next_r.bus = drive(next_r.st, next_r.cmd);
  end

  // state register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '0;
      r.st <= VBCS_IDLE;
      r.ack_q <= 1'b1;
      r.rd_data <= DATA_RESET;
      r.bus <= '{addr: ADDR_RESET, a0: 1'b0, data: DATA_RESET, data_oe: 1'b0, rw: 1'b1,
                 high_byte_strobe_n: 1'b1, low_byte_strobe_n: 1'b1, address_strobe_n: 1'b1,
                 ctrl_page_select_n: 1'b1, vram_page_select_n: 1'b1};
    end else begin
      r <= next_r;
    end
  end

  // outputs
  assign ready_o = (r.st == VBCS_IDLE);
  assign done_o = r.done;
  assign transfer_ack_n_o = transfer_ack_n;
  assign bus_o = r.bus;
  assign rd_data_o = r.rd_data;
  assign rd_valid_o = r.rd_valid;

  // check helper: counts cycles in a state, saturating, so long vectors need no unrolled repeats
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chk_len <= 8'h00;
    end else if (restart) begin
      chk_len <= 8'h00;
    end else if (chk_len != 8'hff) begin
      chk_len <= chk_len + 8'h01;
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // setup vector followed by strobe vector
  sequence setup_vec_s;
    (r.st == VBCS_SETUP) [*8];
  endsequence
  sequence strobe_enter_s;
    $rose(r.st == VBCS_STROBE);
  endsequence

  ack_and_a: assert property (transfer_ack_n_o == (controller_ack_n_i && vram_ack_n_i))
    else $error("combined ack is not the and of both acks");
  sel_gate_a: assert property (!bus_o.ctrl_page_select_n || !bus_o.vram_page_select_n
                               |-> !bus_o.address_strobe_n)
    else $error("page select without address strobe");
  vram_both_a: assert property (!bus_o.vram_page_select_n
                                |-> !bus_o.low_byte_strobe_n && !bus_o.high_byte_strobe_n)
    else $error("video ram access without both strobes");
  period_a: assert property (strobe_enter_s |-> $past(chk_len) == LEN_VEC - 8'h01)
    else $error("setup vector does not last one period");
  setup_max_a: assert property (r.st == VBCS_SETUP |-> chk_len < LEN_VEC)
    else $error("setup vector longer than one period");
  setup_ctl_a: assert property (setup_vec_s |-> bus_o.address_strobe_n && bus_o.rw && bus_o.low_byte_strobe_n)
    else $error("controls not high in setup vector");
  halt_a: assert property (r.st == VBCS_STROBE && !r.ack_seen && !ack_fall |=> r.st == VBCS_STROBE)
    else $error("left strobe vector without ack");
  read_dir_a: assert property (r.st != VBCS_IDLE && !r.cmd.write |-> bus_o.rw && !bus_o.data_oe)
    else $error("read cycle drove direction low or data");
  write_low_a: assert property (r.st == VBCS_STROBE && r.cmd.write |-> !bus_o.rw && bus_o.data_oe)
    else $error("write strobe vector without direction low");
  // capture lands at mid-period plus the offset, 0 to 15 cycles
  capture_a: assert property ($rose(r.st == VBCS_FINAL) && !r.cmd.write && !r.cmd.extra_hold
                              |-> ##[26:41] rd_valid_o)
    else $error("read data not captured by mid-period");
  a0_strobe_a: assert property (!bus_o.ctrl_page_select_n |-> (bus_o.low_byte_strobe_n == !bus_o.a0))
    else $error("a0 does not pick the byte strobe");
endmodule
`default_nettype wire

// [dv/vbcs_board_model.sv]
// behavioural video board: controller and write-only video ram acks, read data
`timescale 1ns/10ps
`default_nettype none
module vbcs_board_model
  import vbcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire vbcs_bus_t bus_i,
  input wire logic [7:0] ws_i, // one wait state, in clock cycles
  output logic controller_ack_n_o,
  output logic vram_ack_n_o,
  output logic [15:0] data_o
);
  int sel_cnt; // cycles since a page select went low
  int hold_cnt; // read data hold window after strobe release
  // page selects already carry the address strobe
  wire logic ctrl_sel = !bus_i.ctrl_page_select_n;
  wire logic vram_sel = !bus_i.vram_page_select_n;
  // read strobe formed from direction and low byte strobe
  wire logic rd_strobe = bus_i.rw && !bus_i.low_byte_strobe_n && ctrl_sel;
  // acks fall after the wait states and rise with the select
  assign controller_ack_n_o = !(ctrl_sel && sel_cnt >= ws_i);
  assign vram_ack_n_o = !(vram_sel && sel_cnt >= 3 * ws_i);
  // data: low byte while reading and briefly after, otherwise toggling
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_cnt <= 0;
      hold_cnt <= 0;
      data_o <= 16'h0000;
    end else begin
      sel_cnt <= (ctrl_sel || vram_sel) ? sel_cnt + 1 : 0;
      hold_cnt <= rd_strobe ? 45 : (hold_cnt > 0 ? hold_cnt - 1 : 0);
      data_o[15:8] <= ~data_o[15:8]; // high byte never driven by controller
      data_o[7:0] <= (rd_strobe || hold_cnt > 0) ? bus_i.addr[7:0] ^ 8'h3c : ~data_o[7:0];
    end
  end
endmodule
`default_nettype wire

// [dv/video_board_bus_cycle_sequencer_test.sv]
// self-checking bench for the bus cycle sequencer against the board model
`timescale 1ns/10ps
`default_nettype none
module video_board_bus_cycle_sequencer_test;
  import vbcs_pkg::*;
  logic clk_i, nrst_i, start_i, ready_o, done_o, transfer_ack_n_o, rd_valid_o;
  logic controller_ack_n, vram_ack_n;
  vbcs_cmd_t cmd_i, c;
  vbcs_cmd_t nc; // next command, kept apart from the checker's copy
  logic [3:0] capture_offset_i;
  logic [7:0] ws;
  vbcs_bus_t bus_o;
  logic [15:0] bus_data, rd_data_o;
  vbcs_cmd_t q[$]; // commands in flight
  int errors, samples_checked, strb_cnt, fin_cnt, seed, r, i;
  logic saw_ack;
  vbcs_sequencer vbcs_sequencer_inst (.clk_i(clk_i), .nrst_i(nrst_i), .start_i(start_i), .cmd_i(cmd_i),
    .capture_offset_i(capture_offset_i), .controller_ack_n_i(controller_ack_n), .vram_ack_n_i(vram_ack_n),
    .ready_o(ready_o), .done_o(done_o), .transfer_ack_n_o(transfer_ack_n_o), .bus_o(bus_o),
    .bus_data_i(bus_data), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o));
  vbcs_board_model vbcs_board_model_inst (.clk_i(clk_i), .nrst_i(nrst_i), .bus_i(bus_o), .ws_i(ws),
    .controller_ack_n_o(controller_ack_n), .vram_ack_n_o(vram_ack_n), .data_o(bus_data));
  // compare and count
  task chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task print_verdict;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // expected pins for the strobe vector (s=1) or the final vector (s=0)
  function automatic vbcs_bus_t exp_bus(input vbcs_cmd_t k, input logic s);
    vbcs_bus_t b;
    logic ct, vr;
    ct = k.addr[19:16] == CTRL_REGION;
    vr = k.addr[19:16] == VRAM_REGION;
    b.addr = k.addr[11:1];
    b.a0 = k.addr[0];
    b.data = k.write ? k.data : 16'h0000;
    b.data_oe = k.write;
    b.rw = !(k.write && s);
    b.low_byte_strobe_n = !(s && (vr || k.addr[0]));
    b.high_byte_strobe_n = !(s && (vr || !k.addr[0]));
    b.address_strobe_n = !s;
    b.ctrl_page_select_n = !(s && ct);
    b.vram_page_select_n = !(s && vr);
    return b;
  endfunction
  // read data pins are a don't-care while data_oe is low
  task cmp_bus(input vbcs_bus_t e, input string msg);
    vbcs_bus_t s;
    s = bus_o;
    if (!c.write) s.data = 16'h0000;
    chk(s, e, msg);
  endtask
  // one bus cycle, bounded wait for done
  task run(input vbcs_cmd_t k, input logic [3:0] ofs);
    int n;
    q.push_back(k);
    start_i <= 1'b1;
    cmd_i <= k;
    capture_offset_i <= ofs;
    @(posedge clk_i);
    start_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (done_o !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      errors++;
      print_verdict;
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // reference model: check the strobe and final vectors of the cycle at the head of the queue
  always @(posedge clk_i) begin
    if (nrst_i && q.size() > 0) begin
      c = q[0];
      chk(transfer_ack_n_o, controller_ack_n & vram_ack_n, "combined ack");
      if (!bus_o.address_strobe_n) begin
        if (strb_cnt == 0) cmp_bus(exp_bus(c, 1'b1), "strobe vector");
        if (!transfer_ack_n_o) saw_ack = 1'b1;
        strb_cnt++;
      end else if (strb_cnt > 0) begin
        chk(saw_ack && strb_cnt > ws * (c.addr[19:16] == VRAM_REGION ? 3 : 1)
          && strb_cnt >= (c.extra_hold ? 2 : 1) * VEC_CYC, 1, "strobe halt");
        cmp_bus(exp_bus(c, 1'b0), "final vector");
        strb_cnt = 0;
        saw_ack = 1'b0;
        fin_cnt = 1;
      end else if (fin_cnt > 0) fin_cnt++;
      if (rd_valid_o) begin
        chk(rd_data_o[7:0], c.addr[8:1] ^ 8'h3c, "read data");
        chk(bus_o.low_byte_strobe_n, !c.extra_hold, "capture strobe");
        if (!c.extra_hold) chk(fin_cnt, CAP_CYC + 2 + capture_offset_i, "capture point");
      end
      if (fin_cnt > 0 || strb_cnt > 0) chk(ready_o, done_o, "ready while busy");
      if (done_o) begin
        chk(fin_cnt, VEC_CYC + 1, "final length");
        fin_cnt = 0;
        void'(q.pop_front());
      end
    end
  end
  // controller write, video ram write, controller read, read with hold
  initial begin
    seed = 32'ha951;
    nrst_i = 1'b0;
    start_i = 1'b0;
    cmd_i = '0;
    capture_offset_i = 4'h0;
    ws = 8'h02;
    errors = 0;
    samples_checked = 0;
    strb_cnt = 0;
    fin_cnt = 0;
    saw_ack = 1'b0;
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    for (i = 0; i < 16; i++) begin
      r = $random(seed);
      ws <= 8'(2 + r[4:0]);
      nc.write = i % 4 < 2;
      nc.extra_hold = i % 4 == 3;
      nc.addr = {(i % 4 == 1) ? VRAM_REGION : CTRL_REGION, r[15:1], nc.write ? r[0] : 1'b1};
      nc.data = r[31:16];
      run(nc, r[19:16]);
    end
    print_verdict;
  end
endmodule
`default_nettype wire
